// *** shared/pcsi_pkg.sv ***
// Types shared by the pc/stack block
package pcsi_pkg;
    typedef logic [12:0] pcsi_pc_t;
    typedef logic [2:0] pcsi_sp_t;
    typedef enum logic [5:0] {
        PCSI_SRC_HOLD = 6'h01,
        PCSI_SRC_STEP = 6'h02,
        PCSI_SRC_PCL = 6'h04,
        PCSI_SRC_JUMP = 6'h08,
        PCSI_SRC_POP = 6'h10,
        PCSI_SRC_VEC = 6'h20
    } pcsi_src_e;
endpackage

// *** shared/pcsi_regs.svh ***
// Register offsets, field positions, reset values and fixed addresses of the pc/stack block
`ifndef PCSI_REGS_SVH
`define PCSI_REGS_SVH
// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define PCSI_IDX_RCF 8'h8E
`define PCSI_IDX_CTRL 8'hA0
`define PCSI_IDX_STATE 8'hA1
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PCSI_RCF_POR_BIT 1
`define PCSI_RCF_BOR_BIT 0
`define PCSI_CTRL_BDE_BIT 0
`define PCSI_STATE_LATCH_LSB 16
`define PCSI_STATE_FSP_LSB 24
`define PCSI_LATCH_JMP_MSB 4
`define PCSI_LATCH_JMP_LSB 3
// ----------------------------------------------------------------
// Reset values and fixed addresses
// ----------------------------------------------------------------
`define PCSI_PC_RST 13'h0000
`define PCSI_LATCH_RST 5'h00
`define PCSI_FSP_RST 8'h00
`define PCSI_CTRL_RST 1'h1
`define PCSI_INT_VEC 13'h0004
`define PCSI_IDP_ADDR 7'h00
`endif

// *** verification/pcsi_exec_model.sv ***
// Far-side model: counts data-file accesses that the addressing block asks for
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Access counter
// ----------------------------------------------------------------
module pcsi_exec_model (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic eff_rd,
    input wire logic eff_wr,
    input wire logic eff_zero,
    output logic [7:0] rd_cnt,
    output logic [7:0] wr_cnt,
    output logic [7:0] zero_cnt
);
    // Counts rather than data: the write data path is not part of this block
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_cnt <= 8'h00;
            wr_cnt <= 8'h00;
            zero_cnt <= 8'h00;
        end else begin
            rd_cnt <= rd_cnt + {7'h00, eff_rd};
            wr_cnt <= wr_cnt + {7'h00, eff_wr};
            zero_cnt <= zero_cnt + {7'h00, eff_zero};
        end
    end
endmodule

// *** verification/program_counter_stack_indirect_tb.sv ***
// Self-checking bench for the program counter, stack and indirect addressing block
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin err_count++; \
    $display("wrong value %s expected %0h seen %0h", nm, exp, got); end end
module program_counter_stack_indirect_tb;
    import pcsi_pkg::*;
    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    localparam logic [8:0] k_step = 9'h001, k_call = 9'h002, k_jmp = 9'h004, k_int = 9'h008;
    localparam logic [8:0] k_ret = 9'h010, k_pcl = 9'h020, k_lat = 9'h040, k_fsp = 9'h080;
    localparam logic [8:0] k_acc = 9'h100;
    logic core_clk = 1'b0, rst_n = 1'b0, por_cause = 1'b1, bor_cause = 1'b0;
    logic step_req = 1'b0, call_req = 1'b0, jump_req = 1'b0, int_req = 1'b0, ret_req = 1'b0;
    logic pcl_wr = 1'b0, latch_wr = 1'b0, fsp_wr = 1'b0, acc_valid = 1'b0, acc_write = 1'b0;
    logic [10:0] jump_target = 11'h000;
    logic [7:0] pcl_wdata = 8'h00, fsp_wdata = 8'h00;
    logic [4:0] latch_wdata = 5'h00;
    logic [6:0] acc_addr = 7'h00;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic pready, pslverr, er, eff_rd, eff_wr, eff_zero;
    logic [8:0] eff_addr;
    logic [7:0] rd_cnt, wr_cnt, zero_cnt;
    logic [10:0] tg;
    pcsi_pc_t program_counter, pcx;
    pcsi_pc_t stk [8];
    int err_count = 0, compares = 0, cycles = 0, sp = 0;
    always #50 core_clk = ~core_clk;
    pcsi_core pcsi_core_inst (.core_clk, .rst_n, .por_cause, .bor_cause, .step_req, .call_req,
        .jump_req, .jump_target, .int_req, .ret_req, .pcl_wr, .pcl_wdata, .latch_wr,
        .latch_wdata, .fsp_wr, .fsp_wdata, .acc_valid, .acc_write, .acc_addr, .program_counter,
        .eff_addr, .eff_rd, .eff_wr, .eff_zero, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr);
    pcsi_exec_model pcsi_exec_model_inst (.core_clk, .rst_n, .eff_rd, .eff_wr, .eff_zero,
        .rd_cnt, .wr_cnt, .zero_cnt);
    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task conclude;
        $display("comparisons %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task put(input logic [8:0] k);
        {acc_valid, fsp_wr, latch_wr, pcl_wr, ret_req, int_req, jump_req, call_req, step_req} <= k;
    endtask
    // One strobe cycle; data byte feeds every data input but jump_target and acc_write, so none is tied
    task core(input logic [8:0] k, input logic [10:0] t, input logic [7:0] d, input logic w);
        @(posedge core_clk);
        put(k);
        jump_target <= t;
        pcl_wdata <= d;
        latch_wdata <= d[4:0];
        fsp_wdata <= d;
        acc_addr <= d[6:0];
        acc_write <= w;
        @(posedge core_clk);
        put(9'h000);
        #1;
    endtask
    // Strobe k1 held n cycles back to back, then k2 for one cycle
    task seq(input logic [8:0] k1, input logic [8:0] k2, input int n, input logic [10:0] t);
        @(posedge core_clk);
        put(k1);
        jump_target <= t;
        repeat (n) @(posedge core_clk);
        put(k2);
        @(posedge core_clk);
        put(9'h000);
        #1;
    endtask
    // Waits for pready as long as it takes; only the cycle ceiling ends a hang
    task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1) begin
            @(posedge core_clk);
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rst(input logic p, input logic b);
        @(posedge core_clk);
        rst_n <= 1'b0;
        por_cause <= p;
        bor_cause <= b;
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        #1;
    endtask
    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            conclude;
        end
    end
    initial begin
        rst(1'b1, 1'b0);
        `CHK("pc", 13'h0000, program_counter)
        apb(1'b0, 12'h238, 32'h0);
        `CHK("flags", 32'h0000_0000, rd)
        apb(1'b0, 12'h280, 32'h0);
        `CHK("ctrl", 32'h0000_0001, rd)
        apb(1'b1, 12'h100, 32'hFFFF_FFFF);
        `CHK("unmapped err", 1'b1, er)
        apb(1'b1, 12'h238, 32'hFFFF_FFFF);
        apb(1'b0, 12'h238, 32'h0);
        `CHK("flags set", 32'h0000_0003, rd)
        `CHK("flags err", 1'b0, er)
        $display("test registers done");
        core(k_step, 11'h000, 8'h00, 1'b0);
        `CHK("pc step", 13'h0001, program_counter)
        core(k_lat, 11'h000, 8'h1F, 1'b0);
        core(k_pcl, 11'h000, 8'hA5, 1'b0);
        `CHK("pc low write", 13'h1FA5, program_counter)
        core(k_lat, 11'h000, 8'h02, 1'b0);
        core(k_pcl, 11'h000, 8'hF0, 1'b0);
        core(k_pcl, 11'h000, 8'h10, 1'b0);
        `CHK("pc computed", 13'h0210, program_counter)
        core(k_lat, 11'h000, 8'h17, 1'b0);
        core(k_jmp, 11'h5A3, 8'h00, 1'b0);
        `CHK("pc jump", 13'h15A3, program_counter)
        apb(1'b1, 12'h284, 32'hFFFF_FFFF);
        apb(1'b0, 12'h284, 32'h0);
        `CHK("state", 32'h0017_15A3, rd)
        $display("test pc loading done");
        core(k_lat, 11'h000, 8'h08, 1'b0);
        for (int i = 0; i < 9; i++) begin
            tg = 11'(i * 64 + 7);
            stk[sp % 8] = program_counter + 13'h0001;
            sp++;
            core(k_call, tg, 8'h00, 1'b0);
            `CHK("pc call", {2'b01, tg}, program_counter)
        end
        for (int i = 0; i < 9; i++) begin
            sp--;
            core(k_ret, 11'h000, 8'h00, 1'b0);
            `CHK("pc return", stk[sp % 8], program_counter)
        end
        seq(k_call, k_ret, 8, 11'h0C3);
        `CHK("pc burst return", 13'h08C4, program_counter)
        pcx = program_counter;
        core(k_int, 11'h000, 8'h00, 1'b0);
        `CHK("pc vector", 13'h0004, program_counter)
        core(k_ret, 11'h000, 8'h00, 1'b0);
        `CHK("pc int exit", pcx, program_counter)
        apb(1'b0, 12'h284, 32'h0);
        `CHK("latch kept", 5'h08, rd[20:16])
        $display("test stack done");
        core(k_fsp, 11'h000, 8'h45, 1'b0);
        core(k_acc, 11'h000, 8'h00, 1'b0);
        `CHK("eff addr", 9'h045, eff_addr)
        `CHK("eff rd", 1'b1, eff_rd)
        core(k_acc, 11'h000, 8'h00, 1'b1);
        `CHK("eff wr", 1'b1, eff_wr)
        core(k_acc, 11'h000, 8'h25, 1'b0);
        `CHK("direct addr", 9'h025, eff_addr)
        core(k_fsp, 11'h000, 8'h80, 1'b0);
        core(k_acc, 11'h000, 8'h00, 1'b0);
        `CHK("eff zero", 1'b1, eff_zero)
        `CHK("bank bit", 1'b0, eff_addr[8])
        core(k_acc, 11'h000, 8'h00, 1'b1);
        `CHK("self write", 1'b0, eff_wr)
        @(posedge core_clk);
        #1;
        `CHK("writes seen", 8'h01, wr_cnt)
        `CHK("zero reads", 8'h01, zero_cnt)
        `CHK("reads seen", 8'h02, rd_cnt)
        $display("test indirect done");
        apb(1'b1, 12'h238, 32'h0000_0003);
        rst(1'b0, 1'b1);
        `CHK("pc brownout", 13'h0000, program_counter)
        apb(1'b0, 12'h238, 32'h0);
        `CHK("flags brownout", 32'h0000_0002, rd)
        apb(1'b1, 12'h238, 32'h0000_0003);
        rst(1'b0, 1'b0);
        apb(1'b0, 12'h238, 32'h0);
        `CHK("flags other", 32'h0000_0003, rd)
        rst(1'b1, 1'b0);
        apb(1'b0, 12'h238, 32'h0);
        `CHK("flags poweron", 2'b00, rd[1:0])
        apb(1'b1, 12'h238, 32'h0000_0003);
        apb(1'b1, 12'h280, 32'h0);
        rst(1'b0, 1'b1);
        apb(1'b0, 12'h238, 32'h0);
        `CHK("flags detect off", 32'h0000_0003, rd)
        apb(1'b0, 12'h280, 32'h0);
        `CHK("ctrl kept", 32'h0000_0000, rd)
        $display("test reset causes done");
        conclude;
    end
endmodule

// *** verilog/pcsi_core.sv ***
// Program counter, return stack, indirect addressing and reset-cause flags
`timescale 1ns/1ps
`include "pcsi_regs.svh"
// What this block does
// - Program counter is 13 bits; low byte readable and writable by instructions.
// - Upper five bits never accessed directly; loaded from latch, jump target, stack, vector or increment.
// - Every reset clears the whole program counter.
// - Writing the low byte loads upper bits from latch bits 4..0.
// - Call or jump takes only latch bits 4 and 3 above the target.
// - Arithmetic write to low byte jumps without carry into upper bits.
// - Return stack holds eight entries of 13 bits.
// - Stack and its pointer lie outside every address space, unreadable.
// - Call and interrupt vectoring push the program counter.
// - Return, return-with-literal and interrupt exit pop into the program counter.
// - Pushes and pops leave the upper latch untouched.
// - Stack is circular: ninth push overwrites the first entry.
// - No overflow or underflow indication exists.
// - Indirect port has no storage; it reaches the location in the pointer.
// - Indirect read through a pointer at the port itself returns zero.
// - Indirect write through a pointer at the port itself stores nothing.
// - Effective address is bank bit over 8-bit pointer; bank bit held clear.
// - Flag bit 1 reads 0 after power-on reset; software then sets it.
// - Flag bit 0 cleared by brown-out reset; software then sets it.
// - Brown-out flag cleared by power-on reset, meaningless with detection disabled.
// - Flag register bits 7..2 read as zero.
module pcsi_core #(
    parameter int PC_W = 13,
    parameter int DEPTH = 8
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic por_cause,
    input wire logic bor_cause,
    input wire logic step_req,
    input wire logic call_req,
    input wire logic jump_req,
    input wire logic [10:0] jump_target,
    input wire logic int_req,
    input wire logic ret_req,
    input wire logic pcl_wr,
    input wire logic [7:0] pcl_wdata,
    input wire logic latch_wr,
    input wire logic [4:0] latch_wdata,
    input wire logic fsp_wr,
    input wire logic [7:0] fsp_wdata,
    input wire logic acc_valid,
    input wire logic acc_write,
    input wire logic [6:0] acc_addr,
    output pcsi_pkg::pcsi_pc_t program_counter,
    output logic [8:0] eff_addr,
    output logic eff_rd,
    output logic eff_wr,
    output logic eff_zero,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    import pcsi_pkg::*;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic pcsi_sp_t sp_move(input pcsi_sp_t sp, input logic down);
        sp_move = down ? sp - 3'h1 : sp + 3'h1;
    endfunction

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    pcsi_pc_t pc_ff;
    pcsi_pc_t nxt_pc;
    logic [4:0] latch_ff;
    logic [7:0] fsp_ff;
    pcsi_sp_t sp_ff;
    pcsi_sp_t nxt_sp;
    pcsi_pc_t stack_mem [DEPTH];
    pcsi_src_e src;
    logic push_go;
    logic pop_go;
    pcsi_pc_t push_val;
    pcsi_pc_t pop_val;

    // ----------------------------------------------------------------
    // Program counter source
    // ----------------------------------------------------------------
    // Vectoring outranks everything so an interrupt is never swallowed
    assign src = int_req ? PCSI_SRC_VEC :
                 (call_req | jump_req) ? PCSI_SRC_JUMP :
                 ret_req ? PCSI_SRC_POP :
                 pcl_wr ? PCSI_SRC_PCL :
                 step_req ? PCSI_SRC_STEP : PCSI_SRC_HOLD;
    assign push_go = int_req | (call_req & ~int_req);
    assign pop_go = (src == PCSI_SRC_POP);
    // Interrupt resumes the instruction it pre-empted; call resumes after itself
    assign push_val = int_req ? pc_ff : pc_ff + 13'h0001;
    assign pop_val = stack_mem[sp_move(sp_ff, 1'b1)];

    always_comb begin
        case (src)
            PCSI_SRC_VEC: nxt_pc = `PCSI_INT_VEC;
            PCSI_SRC_JUMP: nxt_pc = {latch_ff[`PCSI_LATCH_JMP_MSB:`PCSI_LATCH_JMP_LSB],
                                     jump_target};
            PCSI_SRC_POP: nxt_pc = pop_val;
            // No carry into the upper bits: tables must not straddle a 256-word block
            PCSI_SRC_PCL: nxt_pc = {latch_ff, pcl_wdata};
            PCSI_SRC_STEP: nxt_pc = pc_ff + 13'h0001;
            PCSI_SRC_HOLD: nxt_pc = pc_ff;
            default: nxt_pc = pc_ff;
        endcase
    end

    // Simultaneous push and pop cancel on the pointer
    assign nxt_sp = (push_go & ~pop_go) ? sp_move(sp_ff, 1'b0) :
                    (pop_go & ~push_go) ? sp_move(sp_ff, 1'b1) : sp_ff;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pc_ff <= `PCSI_PC_RST;
            sp_ff <= 3'h0;
        end else begin
            pc_ff <= nxt_pc;
            sp_ff <= nxt_sp;
        end
    end

    // Stack array has no reset: stale entries are part of the wrap behaviour
    always_ff @(posedge core_clk) begin
        if (push_go) begin
            stack_mem[sp_ff] <= push_val;
        end
    end

    // Only the instruction path writes the latch; stack traffic never does
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            latch_ff <= `PCSI_LATCH_RST;
            fsp_ff <= `PCSI_FSP_RST;
        end else begin
            if (latch_wr) begin
                latch_ff <= latch_wdata;
            end
            if (fsp_wr) begin
                fsp_ff <= fsp_wdata;
            end
        end
    end

    assign program_counter = pc_ff;

    // ----------------------------------------------------------------
    // Indirect addressing
    // ----------------------------------------------------------------
    logic is_ind;
    logic self_ptr;
    logic [8:0] nxt_eff;
    logic [8:0] eff_addr_ff;
    logic eff_rd_ff;
    logic eff_wr_ff;
    logic eff_zero_ff;

    assign is_ind = acc_valid & (acc_addr == `PCSI_IDP_ADDR);
    assign self_ptr = (fsp_ff[6:0] == `PCSI_IDP_ADDR);
    // Bank bit is not implemented on this part and is tied clear
    assign nxt_eff = is_ind ? {1'b0, fsp_ff} : {2'b00, acc_addr};

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            eff_addr_ff <= 9'h000;
            eff_rd_ff <= 1'b0;
            eff_wr_ff <= 1'b0;
            eff_zero_ff <= 1'b0;
        end else begin
            eff_addr_ff <= nxt_eff;
            eff_rd_ff <= acc_valid & ~acc_write & ~(is_ind & self_ptr);
            eff_wr_ff <= acc_valid & acc_write & ~(is_ind & self_ptr);
            eff_zero_ff <= is_ind & self_ptr & ~acc_write;
        end
    end

    assign eff_addr = eff_addr_ff;
    assign eff_rd = eff_rd_ff;
    assign eff_wr = eff_wr_ff;
    assign eff_zero = eff_zero_ff;

    // ----------------------------------------------------------------
    // Reset-cause flags
    // ----------------------------------------------------------------
    logic capt_ff;
    logic por_ff;
    logic bor_ff;
    logic bde_ff;
    logic wr_go;
    logic [7:0] reg_idx;
    logic hit_rcf;
    logic hit_ctrl;
    logic hit_state;
    logic hit_any;
    logic [31:0] rd_mux;

    // Flags keep their value across resets, so they have no reset term;
    // the cause is caught at the first edge after release.
    // The detect enable lives here too: only a power-on reset or a control write re-enables capture
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            capt_ff <= 1'b0;
        end else begin
            capt_ff <= 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!capt_ff && por_cause) begin
            por_ff <= 1'b0;
            bor_ff <= 1'b0;
            bde_ff <= `PCSI_CTRL_RST;
        end else if (!capt_ff && bor_cause && bde_ff) begin
            bor_ff <= 1'b0;
        end else if (wr_go && hit_rcf) begin
            por_ff <= pwdata[`PCSI_RCF_POR_BIT];
            bor_ff <= pwdata[`PCSI_RCF_BOR_BIT];
        end else if (wr_go && hit_ctrl) begin
            bde_ff <= pwdata[`PCSI_CTRL_BDE_BIT];
        end
    end

    // ----------------------------------------------------------------
    // APB slave
    // ----------------------------------------------------------------
    logic pready_ff;
    logic pslverr_ff;
    logic [31:0] prdata_ff;

    assign reg_idx = paddr[9:2];
    assign hit_rcf = (paddr[11:10] == 2'b00) && (reg_idx == `PCSI_IDX_RCF);
    assign hit_ctrl = (paddr[11:10] == 2'b00) && (reg_idx == `PCSI_IDX_CTRL);
    assign hit_state = (paddr[11:10] == 2'b00) && (reg_idx == `PCSI_IDX_STATE);
    assign hit_any = hit_rcf | hit_ctrl | hit_state;
    assign wr_go = psel & penable & pready_ff & pwrite & hit_any;
    assign rd_mux = hit_rcf ? {30'h0, por_ff, bor_ff} :
                    hit_ctrl ? {31'h0, bde_ff} :
                    hit_state ? {fsp_ff, 3'h0, latch_ff, 3'h0, pc_ff} : 32'h0;

    // One wait state: pready rises in the second access cycle
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0;
        end else begin
            pready_ff <= psel & penable & ~pready_ff;
            pslverr_ff <= psel & penable & ~pready_ff & ~hit_any;
            prdata_ff <= (psel & penable & ~pready_ff & ~pwrite) ? rd_mux : 32'h0;
        end
    end

    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign prdata = prdata_ff;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    AST_PCL_LOAD:
    assert property (@(posedge core_clk) disable iff (!rst_n)
        (src == PCSI_SRC_PCL) |=> pc_ff == {$past(latch_ff), $past(pcl_wdata)})
        else $error("low byte write did not load latch into upper bits");

    AST_JUMP_UPPER:
    assert property (@(posedge core_clk) disable iff (!rst_n)
        (src == PCSI_SRC_JUMP) |=> pc_ff[12:11] == $past(latch_ff[4:3])
            && pc_ff[10:0] == $past(jump_target))
        else $error("jump did not take latch bits 4 and 3");

    AST_CALL_RETURN:
    assert property (@(posedge core_clk) disable iff (!rst_n)
        (call_req && !int_req) ##1 (ret_req && !int_req && !call_req && !jump_req)
            |=> pc_ff == $past(pc_ff, 2) + 13'h0001)
        else $error("return did not restore the call site");

    AST_INT_PUSH:
    assert property (@(posedge core_clk) disable iff (!rst_n)
        int_req |=> pc_ff == `PCSI_INT_VEC && sp_ff == $past(sp_ff) + 3'h1)
        else $error("interrupt did not vector and push");

    AST_LATCH_KEPT:
    assert property (@(posedge core_clk) disable iff (!rst_n)
        (push_go || pop_go) && !latch_wr |=> $stable(latch_ff))
        else $error("stack traffic changed the latch");

    AST_SP_WRAP:
    assert property (@(posedge core_clk) disable iff (!rst_n)
        (push_go && !pop_go)[*8] |=> sp_ff == $past(sp_ff, 8))
        else $error("stack pointer did not wrap after eight pushes");

    AST_IND_ADDR:
    assert property (@(posedge core_clk) disable iff (!rst_n)
        is_ind |=> eff_addr_ff == {1'b0, $past(fsp_ff)})
        else $error("indirect address not formed from pointer");

    AST_SELF_READ:
    assert property (@(posedge core_clk) disable iff (!rst_n)
        is_ind && self_ptr && !acc_write |=> eff_zero_ff && !eff_rd_ff)
        else $error("self-pointing read did not return zero");

    AST_SELF_WRITE:
    assert property (@(posedge core_clk) disable iff (!rst_n)
        is_ind && self_ptr && acc_write |=> !eff_wr_ff)
        else $error("self-pointing write was not suppressed");

    AST_RCF_UPPER:
    assert property (@(posedge core_clk) disable iff (!rst_n)
        psel && penable && pready_ff && !pwrite && hit_rcf |-> prdata_ff[31:2] == 30'h0)
        else $error("flag register upper bits not zero");

    AST_POR_FLAG:
    assert property (@(posedge core_clk) disable iff (!rst_n)
        !capt_ff && por_cause |=> !por_ff)
        else $error("power-on reset did not clear the flag");

    AST_STEP_INC:
    assert property (@(posedge core_clk) disable iff (!rst_n)
        (src == PCSI_SRC_STEP) |=> pc_ff == $past(pc_ff) + 13'h0001)
        else $error("step did not advance the program counter");

    AST_BOR_FLAG:
    assert property (@(posedge core_clk) disable iff (!rst_n)
        !capt_ff && bor_cause && !por_cause && bde_ff |=> !bor_ff)
        else $error("brown-out reset did not clear the flag");

    AST_BDE_OFF:
    assert property (@(posedge core_clk) disable iff (!rst_n)
        !capt_ff && !por_cause && !bde_ff |=> $stable(bor_ff))
        else $error("brown-out flag moved with detection disabled");

    AST_EFF_DIRECT:
    assert property (@(posedge core_clk) disable iff (!rst_n)
        acc_valid && !is_ind |=> eff_addr_ff == {2'b00, $past(acc_addr)})
        else $error("direct access address not passed through");
endmodule
